// File: src/fsp_pkg.sv
package fsp_pkg;

  // ----------------------------------------------------------------
  // Flash geometry (word addressed)
  // ----------------------------------------------------------------
  localparam int ADDR_W = 13;
  localparam logic [12:0] HALT_START = 13'h1c00;

  // Boot region start per boot-size fuse code; all lie at or above HALT_START
  localparam logic [12:0] BOOT_START_00 = 13'h1c00;
  localparam logic [12:0] BOOT_START_01 = 13'h1e00;
  localparam logic [12:0] BOOT_START_10 = 13'h1f00;
  localparam logic [12:0] BOOT_START_11 = 13'h1f80;

  // ----------------------------------------------------------------
  // Store-program command codes
  // ----------------------------------------------------------------
  localparam logic [1:0] CMD_ERASE = 2'h0;
  localparam logic [1:0] CMD_WRITE = 2'h1;
  localparam logic [1:0] CMD_LOCK = 2'h2;
  localparam logic [1:0] CMD_NONE = 2'h3;

  // ----------------------------------------------------------------
  // Boot lock bits: [1:0] application set, [3:2] boot set; 1 = unprogrammed
  // ----------------------------------------------------------------
  localparam logic [3:0] LOCK_RESET = 4'hf;
  localparam int LOCK_APP_LSB = 0;
  localparam int LOCK_BOOT_LSB = 2;

  typedef enum logic [1:0] {
    FSP_IDLE,
    FSP_BUSY_CONC,
    FSP_BUSY_HALT
  } fsp_state_t;

endpackage : fsp_pkg

// File: src/fsp_region_if.sv
`timescale 1ns/10ps
interface fsp_region_if;
  logic [1:0] boot_size;
  logic [12:0] pc_addr;
  logic [12:0] tgt_addr;
  logic pc_in_boot;
  logic tgt_in_boot;
  logic tgt_in_halt;

  modport ctrl (output boot_size, output pc_addr, output tgt_addr,
                input pc_in_boot, input tgt_in_boot, input tgt_in_halt);
  modport dec (input boot_size, input pc_addr, input tgt_addr,
               output pc_in_boot, output tgt_in_boot, output tgt_in_halt);
endinterface : fsp_region_if

// File: src/fsp_region_dec.sv
`timescale 1ns/10ps
module fsp_region_dec (
  fsp_region_if.dec rif
);

  function automatic logic [12:0] fsp_boot_start(input logic [1:0] sz);
    logic [12:0] s;
    s = fsp_pkg::BOOT_START_00;
    unique case (sz)
      2'h0: s = fsp_pkg::BOOT_START_00;
      2'h1: s = fsp_pkg::BOOT_START_01;
      2'h2: s = fsp_pkg::BOOT_START_10;
      2'h3: s = fsp_pkg::BOOT_START_11;
    endcase
    return s;
  endfunction : fsp_boot_start

  // Boot boundary follows the fuse; halting boundary is fixed
  assign rif.pc_in_boot = rif.pc_addr >= fsp_boot_start(rif.boot_size);
  assign rif.tgt_in_boot = rif.tgt_addr >= fsp_boot_start(rif.boot_size);
  assign rif.tgt_in_halt = rif.tgt_addr >= fsp_pkg::HALT_START;

endmodule : fsp_region_dec

// File: src/fsp_section_ctrl.sv
`timescale 1ns/10ps
// Overview of operation
// - A store-program request issued from application code is refused.
// - A request issued from boot code may target any address, boot pages included.
// - The boot-size fuses set the boot boundary and each region has its own lock pair.
// - A fixed boundary splits flash into concurrent-read and halting regions.
// - Programming a concurrent-read page leaves the CPU running from the halting region.
// - Programming a halting-region page stalls the CPU for the whole operation.
// - Reads of the concurrent-read region are blocked during any programming.
// - The busy flag reads one while those reads are blocked.
// - The busy flag stays set after completion until software clears it.
// - For every fuse setting the boot region lies inside the halting region.
// - The target address is captured when programming starts.
// - Lock bits can only be programmed, except by a whole-chip erase or a reset.
module fsp_section_ctrl (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [1:0] boot_size_fuses,
  input wire logic store_program_valid,
  input wire logic [1:0] store_program_cmd,
  input wire logic [12:0] store_program_pc,
  input wire logic [12:0] store_program_addr,
  input wire logic [3:0] store_program_lock_data,
  input wire logic busy_clear_req,
  input wire logic ext_lock_wr,
  input wire logic [3:0] ext_lock_data,
  input wire logic chip_erase,
  input wire logic flash_done,
  output logic flash_start_q,
  output logic [1:0] flash_cmd_q,
  output logic [12:0] flash_addr_q,
  output logic cpu_stall_q,
  output logic concurrent_read_block_q,
  output logic concurrent_read_busy_flag_q,
  output logic store_program_refused_q,
  output logic [3:0] boot_lock_q
);

  // ----------------------------------------------------------------
  // Region decode
  // ----------------------------------------------------------------
  fsp_region_if rif ();

  assign rif.boot_size = boot_size_fuses;
  assign rif.pc_addr = store_program_pc;
  assign rif.tgt_addr = store_program_addr;

  fsp_region_dec u_dec (
    .rif (rif.dec)
  );

  // Lock pair value 2'b11 or 2'b01 lets writes through; bit 0 programmed forbids them
  function automatic logic fsp_write_ok(input logic [1:0] pair);
    return pair[0];
  endfunction : fsp_write_ok

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  fsp_pkg::fsp_state_t state_q, state_d;
  logic start_d;
  logic [1:0] cmd_d;
  logic [12:0] addr_d;
  logic stall_d;
  logic block_d;
  logic busy_d;
  logic refused_d;
  logic [3:0] lock_d;
  logic from_boot;
  logic tgt_ok;
  logic is_prog;

  always_comb begin
    from_boot = rif.pc_in_boot;
    is_prog = (store_program_cmd == fsp_pkg::CMD_ERASE) ||
              (store_program_cmd == fsp_pkg::CMD_WRITE);
    // Boot code may reach any page; only the lock pair of the target region gates it
    tgt_ok = rif.tgt_in_boot ?
             fsp_write_ok(boot_lock_q[fsp_pkg::LOCK_BOOT_LSB +: 2]) :
             fsp_write_ok(boot_lock_q[fsp_pkg::LOCK_APP_LSB +: 2]);
    state_d = state_q;
    start_d = 1'b0;
    cmd_d = flash_cmd_q;
    addr_d = flash_addr_q;
    stall_d = cpu_stall_q;
    block_d = concurrent_read_block_q;
    busy_d = concurrent_read_busy_flag_q;
    refused_d = 1'b0;
    lock_d = boot_lock_q;
    unique case (state_q)
      fsp_pkg::FSP_IDLE: begin
        if (busy_clear_req) begin
          busy_d = 1'b0;
        end
        if (store_program_valid && store_program_cmd != fsp_pkg::CMD_NONE) begin
          if (!from_boot) begin
            refused_d = 1'b1;
          end else if (store_program_cmd == fsp_pkg::CMD_LOCK) begin
            lock_d = boot_lock_q & store_program_lock_data;
          end else if (is_prog && !tgt_ok) begin
            refused_d = 1'b1;
          end else begin
            start_d = 1'b1;
            cmd_d = store_program_cmd;
            addr_d = store_program_addr;
            block_d = 1'b1;
            busy_d = 1'b1;
            if (rif.tgt_in_halt) begin
              stall_d = 1'b1;
              state_d = fsp_pkg::FSP_BUSY_HALT;
            end else begin
              stall_d = 1'b0;
              state_d = fsp_pkg::FSP_BUSY_CONC;
            end
          end
        end
      end
      fsp_pkg::FSP_BUSY_CONC, fsp_pkg::FSP_BUSY_HALT: begin
        if (store_program_valid) begin
          refused_d = 1'b1;
        end
        if (flash_done) begin
          // Fetch picks up where it stopped since the CPU only held its state
          stall_d = 1'b0;
          block_d = 1'b0;
          state_d = fsp_pkg::FSP_IDLE;
        end
      end
      default: begin
        state_d = fsp_pkg::FSP_IDLE;
        stall_d = 1'b0;
        block_d = 1'b0;
      end
    endcase
    if (ext_lock_wr) begin
      lock_d = lock_d & ext_lock_data;
    end
    if (chip_erase) begin
      lock_d = fsp_pkg::LOCK_RESET;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_q <= fsp_pkg::FSP_IDLE;
      flash_start_q <= 1'b0;
      flash_cmd_q <= fsp_pkg::CMD_NONE;
      flash_addr_q <= 13'h0000;
      cpu_stall_q <= 1'b0;
      concurrent_read_block_q <= 1'b0;
      concurrent_read_busy_flag_q <= 1'b0;
      store_program_refused_q <= 1'b0;
      boot_lock_q <= fsp_pkg::LOCK_RESET;
    end else begin
      state_q <= state_d;
      flash_start_q <= start_d;
      flash_cmd_q <= cmd_d;
      flash_addr_q <= addr_d;
      cpu_stall_q <= stall_d;
      concurrent_read_block_q <= block_d;
      concurrent_read_busy_flag_q <= busy_d;
      store_program_refused_q <= refused_d;
      boot_lock_q <= lock_d;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  AST_APP_REFUSED: assert property (
    (state_q == fsp_pkg::FSP_IDLE && store_program_valid && !rif.pc_in_boot &&
     store_program_cmd != fsp_pkg::CMD_NONE) |=> store_program_refused_q && !flash_start_q)
    else $error("store-program from application code was not refused");

  AST_BOOT_STARTS: assert property (
    (state_q == fsp_pkg::FSP_IDLE && store_program_valid && rif.pc_in_boot && is_prog &&
     tgt_ok) |=> flash_start_q && flash_addr_q == $past(store_program_addr))
    else $error("permitted boot-code programming did not start");

  AST_ADDR_HELD: assert property (
    (state_q != fsp_pkg::FSP_IDLE && !flash_done) |=> $stable(flash_addr_q))
    else $error("target address changed during programming");

  AST_HALT_STALLS: assert property (
    state_q == fsp_pkg::FSP_BUSY_HALT |-> cpu_stall_q)
    else $error("cpu not stalled during halting-region operation");

  AST_CONC_RUNS: assert property (
    state_q == fsp_pkg::FSP_BUSY_CONC |-> !cpu_stall_q)
    else $error("cpu stalled during concurrent-read-region operation");

  AST_BLOCK_BUSY: assert property (
    state_q != fsp_pkg::FSP_IDLE |-> concurrent_read_block_q && concurrent_read_busy_flag_q)
    else $error("concurrent region not blocked or busy flag low");

  AST_BUSY_STICKY: assert property (
    (concurrent_read_busy_flag_q && !busy_clear_req) |=> concurrent_read_busy_flag_q)
    else $error("busy flag dropped without a clear");

  // A second request would overwrite the captured address if it were taken
  AST_BUSY_REFUSES: assert property (
    (state_q != fsp_pkg::FSP_IDLE && store_program_valid) |=>
      store_program_refused_q && !flash_start_q)
    else $error("request taken while an operation was running");

  AST_CLEAR_IN_IDLE: assert property (
    (state_q == fsp_pkg::FSP_IDLE && busy_clear_req && !store_program_valid) |=>
      !concurrent_read_busy_flag_q)
    else $error("busy flag not cleared by an idle clear request");

  AST_RESUME: assert property (
    (state_q == fsp_pkg::FSP_BUSY_HALT && flash_done) |=>
      !cpu_stall_q && state_q == fsp_pkg::FSP_IDLE)
    else $error("cpu did not resume after halting-region operation");

  AST_LOCK_ONE_WAY: assert property (
    !chip_erase |=> (boot_lock_q & ~$past(boot_lock_q)) == 4'h0)
    else $error("lock bit returned to unprogrammed without chip erase");

  AST_BOOT_IN_HALT: assert property (
    rif.tgt_in_boot |-> rif.tgt_in_halt)
    else $error("boot region reaches outside the halting region");

endmodule : fsp_section_ctrl

// File: test/fsp_flash_model.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Flash array stand-in: finishes each started operation after lat cycles
// ----------------------------------------------------------------
module fsp_flash_model (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic start,
  input wire logic [3:0] lat,
  output logic done
);
  logic [3:0] cnt_q;
  // A latency of zero is not supported: a zero count never reaches one, so done never rises
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cnt_q <= 4'h0;
      done <= 1'b0;
    end else begin
      done <= (cnt_q == 4'h1);
      if (start) begin
        cnt_q <= lat;
      end else if (cnt_q != 4'h0) begin
        cnt_q <= cnt_q - 4'h1;
      end
    end
  end
endmodule : fsp_flash_model

// File: test/flash_self_program_section_control_tb_top.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Bench: CPU side driven here, array side by the flash model
// ----------------------------------------------------------------
module flash_self_program_section_control_tb_top;
  typedef struct packed {
    logic [1:0] fuse;
    logic [1:0] cmd;
    logic [12:0] pc;
    logic [12:0] addr;
    logic refd;
    logic stall;
  } fsp_row_t;
  logic clk = 1'b0;
  logic reset_n, valid, clr, ext_wr, cerase, done;
  logic [1:0] fuse, cmd, cmd_q;
  logic [12:0] pc, addr, addr_q;
  logic [3:0] lockd, ext_d, lock, lat;
  logic start_q, stall, blk, busy, refd;
  int num_errors, cmp_count;
  fsp_row_t rows [6] = '{
    '{2'h0, 2'h1, 13'h1c00, 13'h0000, 1'b0, 1'b0},
    '{2'h0, 2'h1, 13'h1bff, 13'h0000, 1'b1, 1'b0},
    '{2'h1, 2'h0, 13'h1dff, 13'h1c00, 1'b1, 1'b0},
    '{2'h1, 2'h0, 13'h1e00, 13'h1e00, 1'b0, 1'b1},
    '{2'h2, 2'h1, 13'h1f00, 13'h1c00, 1'b0, 1'b1},
    '{2'h3, 2'h0, 13'h1f80, 13'h1bff, 1'b0, 1'b0}};
  always #50 clk = ~clk;
  fsp_section_ctrl dut (.clk(clk), .reset_n(reset_n), .boot_size_fuses(fuse),
    .store_program_valid(valid), .store_program_cmd(cmd), .store_program_pc(pc),
    .store_program_addr(addr), .store_program_lock_data(lockd), .busy_clear_req(clr),
    .ext_lock_wr(ext_wr), .ext_lock_data(ext_d), .chip_erase(cerase), .flash_done(done),
    .flash_start_q(start_q), .flash_cmd_q(cmd_q), .flash_addr_q(addr_q),
    .cpu_stall_q(stall), .concurrent_read_block_q(blk), .concurrent_read_busy_flag_q(busy),
    .store_program_refused_q(refd), .boot_lock_q(lock));
  fsp_flash_model array (.clk(clk), .reset_n(reset_n), .start(start_q), .lat(lat),
    .done(done));
  task automatic summarize();
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : summarize
  task automatic chk(input logic [12:0] s, input logic [12:0] e);
    cmp_count++;
    if (s !== e) begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic chk_reset();
    chk(13'({cmd_q, lock, start_q, stall, blk, busy, refd}),
        13'({fsp_pkg::CMD_NONE, fsp_pkg::LOCK_RESET, 5'h00}));
    chk(addr_q, 13'h0000);
  endtask : chk_reset
  task automatic issue(input logic [1:0] c, input logic [12:0] p, input logic [12:0] a,
                       input logic [3:0] l);
    @(negedge clk);
    valid = 1'b1;
    cmd = c;
    pc = p;
    addr = a;
    lockd = l;
    @(negedge clk);
    valid = 1'b0;
  endtask : issue
  // Software never fetches from the blocked region and clears busy before moving on
  task automatic wait_done(input logic st);
    int i;
    for (i = 0; i < 40 && done !== 1'b1; i++) begin
      @(negedge clk);
      chk(13'(stall), 13'(st));
      chk(13'(blk & busy), 13'h1);
    end
    if (done !== 1'b1) begin
      num_errors++;
      summarize();
    end
    @(negedge clk);
    chk(13'({stall, blk, busy}), 13'h1);
    clr = 1'b1;
    @(negedge clk);
    clr = 1'b0;
    chk(13'(busy), 13'h0);
  endtask : wait_done
  task automatic run(input fsp_row_t r);
    fuse = r.fuse;
    issue(r.cmd, r.pc, r.addr, 4'hf);
    chk(13'({start_q, refd}), 13'({!r.refd, r.refd}));
    if (!r.refd) begin
      chk(addr_q, r.addr);
      chk(13'(cmd_q), 13'(r.cmd));
      wait_done(r.stall);
    end
  endtask : run
  initial begin
    {reset_n, valid, clr, ext_wr, cerase, fuse, pc, addr} = '0;
    {cmd, lockd, ext_d, lat} = {2'h3, 4'hf, 4'hf, 4'h2};
    num_errors = 0;
    cmp_count = 0;
    repeat (8) @(negedge clk);
    reset_n = 1'b1;
    chk_reset();
    foreach (rows[k]) begin
      run(rows[k]);
    end
    // Boot code programs the application lock pair, then app writes are refused
    issue(fsp_pkg::CMD_LOCK, 13'h1f80, 13'h0000, 4'he);
    chk(13'(lock), 13'he);
    run('{2'h3, 2'h1, 13'h1f80, 13'h0000, 1'b1, 1'b0});
    run('{2'h3, 2'h1, 13'h1f80, 13'h1f80, 1'b0, 1'b1});
    ext_wr = 1'b1;
    ext_d = 4'h7;
    @(negedge clk);
    ext_wr = 1'b0;
    chk(13'(lock), 13'h6);
    issue(fsp_pkg::CMD_LOCK, 13'h1f80, 13'h0000, 4'hf);
    chk(13'(lock), 13'h6);
    cerase = 1'b1;
    @(negedge clk);
    cerase = 1'b0;
    chk(13'(lock), 13'hf);
    // A request with no command does nothing; a start beats a clear in the same cycle
    issue(fsp_pkg::CMD_NONE, 13'h1f80, 13'h0000, 4'h0);
    chk(13'({start_q, refd, lock}), 13'({2'b00, fsp_pkg::LOCK_RESET}));
    clr = 1'b1;
    issue(fsp_pkg::CMD_WRITE, 13'h1f80, 13'h0080, 4'hf);
    clr = 1'b0;
    chk(13'({start_q, busy}), 13'h3);
    wait_done(1'b0);
    // Slow array: a second request while busy is refused and the address is kept
    lat = 4'h8;
    issue(fsp_pkg::CMD_WRITE, 13'h1f80, 13'h0040, 4'hf);
    issue(fsp_pkg::CMD_ERASE, 13'h1f80, 13'h0100, 4'hf);
    chk(13'(refd), 13'h1);
    chk(addr_q, 13'h0040);
    clr = 1'b1;
    @(negedge clk);
    clr = 1'b0;
    chk(13'(busy), 13'h1);
    wait_done(1'b0);
    // Reset in mid-operation drops the stall and the sticky busy flag
    issue(fsp_pkg::CMD_WRITE, 13'h1f80, 13'h1f80, 4'hf);
    chk(13'({stall, busy}), 13'h3);
    reset_n = 1'b0;
    repeat (2) @(negedge clk);
    reset_n = 1'b1;
    chk_reset();
    issue(fsp_pkg::CMD_WRITE, 13'h1f80, 13'h0000, 4'hf);
    chk(13'(start_q), 13'h1);
    wait_done(1'b0);
    summarize();
  end
endmodule : flash_self_program_section_control_tb_top
